//--- core/sctrf_fifo.sv
`timescale 1ns/1ps
module sctrf_fifo
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (cnt_ff != DEPTH[AW:0]);
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem[rd_ff];

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ff] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst || flush)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			if (push)
				wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
			if (pop)
				rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- core/sctrf_pkg.sv
package sctrf_pkg;

	// Host command set, already parsed from the command strings
	typedef enum logic [2:0] {
		CMD_CONFIGURE,
		CMD_MEASURE,
		CMD_READ,
		CMD_INITIATE,
		CMD_FETCH,
		CMD_ABORT,
		CMD_DEV_CLEAR,
		CMD_TRIG_SOURCE
	} sctrf_cmd_e;

	localparam int SCTRF_DATA_W = 32;
	localparam int SCTRF_FIFO_DEPTH = 8;
	localparam int SCTRF_PTR_W = 16;
	localparam int SCTRF_MEM_DEPTH = 50000;
	localparam logic [15:0] SCTRF_MEM_LAST = 16'hc34f;
	localparam logic [15:0] SCTRF_MEM_FULL = 16'hc350;

	// Resolution steps: index 0 is shortest integration (0.02) up to index 6 (100)
	localparam logic [2:0] SCTRF_RES_MAX = 3'h6;
	localparam logic [2:0] SCTRF_RES_DEF = 3'h2;
	// Integration time in hundredths of a power_line_cycle
	localparam logic [13:0] SCTRF_INTEG_HPLC [0:6] = '{14'h0002, 14'h0014, 14'h0064, 14'h00c8,
		14'h03e8, 14'h07d0, 14'h2710};
	localparam logic [4:0] SCTRF_RES_BITS [0:6] = '{5'h0f, 5'h12, 5'h14, 5'h15, 5'h18, 5'h19, 5'h1a};

	// Function codes for frequency and period share one 3 Hz to 300 kHz range
	localparam logic [3:0] SCTRF_FUNC_FREQ = 4'h6;
	localparam logic [3:0] SCTRF_FUNC_PERIOD = 4'h7;
	localparam logic [2:0] SCTRF_FREQ_RANGE = 3'h0;
	localparam logic [3:0] SCTRF_FUNC_RST = 4'h0;
	localparam logic [2:0] SCTRF_RANGE_RST = 3'h0;
	localparam logic [7:0] SCTRF_CHANS_RST = 8'h01;

endpackage

//--- core/sctrf_top.sv
`timescale 1ns/1ps
// Functional notes
// - Configure loads defaults for the function and leaves the trigger system idle.
// - Read arms wait-for-trigger; scanning starts once the trigger condition holds.
// - Read readings go only to the output buffer; scan halts while it is full.
// - Initiate readings go to 50,000-entry memory; when full, oldest are overwritten.
// - Readings stay in memory until retrieved, however long the host waits.
// - Fetch copies all stored readings to the output buffer without erasing them.
// - Resolution picks one of seven integration times, 0.02 to 100, 15 to 26 bits.
// - Frequency and period use one 3 Hz to 300 kHz range; range sets resolution. Here CMD_RANGE is ignored and CMD_RES_SEL sets resolution.
// - Range argument AUTO enables autoranging instead of a fixed range. Here frequency and period keep SCTRF_FREQ_RANGE with autorange off.
// - Measure applies defaults, triggers at once, and sends readings to output buffer.
// - External source with read: one scan per external trigger pulse to output buffer.
// - Fetch during a running scan completes only after the scan has finished.
// - Abort or device clear stops a running scan.
module sctrf_top
	import sctrf_pkg::*;
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// Host commands
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire sctrf_cmd_e CMD_CODE,
	input wire logic [3:0] CMD_FUNC,
	input wire logic [2:0] CMD_RANGE,
	input wire logic CMD_RANGE_AUTO,
	input wire logic [2:0] CMD_RES_SEL,
	input wire logic [7:0] CMD_CHANS,
	input wire logic CMD_TRIG_EXT,
	// External trigger terminal
	input wire logic EXT_TRIG,
	// Measurement front end
	output logic MEAS_START,
	output logic [7:0] MEAS_CHAN,
	input wire logic MEAS_DONE,
	input wire logic [SCTRF_DATA_W-1:0] MEAS_DATA,
	// Measurement settings
	output logic [3:0] CFG_FUNC,
	output logic [2:0] CFG_RANGE,
	output logic CFG_AUTO_RANGE,
	output logic [13:0] CFG_INTEG_HPLC,
	output logic [4:0] CFG_RES_BITS,
	output logic TRIG_EXT_SEL,
	// Output buffer
	output logic OUT_VALID,
	input wire logic OUT_READY,
	output logic [SCTRF_DATA_W-1:0] OUT_DATA,
	// Status
	output logic SCAN_BUSY,
	output logic [SCTRF_PTR_W-1:0] MEM_COUNT
);
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT_TRIG, ST_SAMPLE, ST_CONVERT, ST_FETCH_RD, ST_FETCH_PUSH} sctrf_state_e;

	function automatic logic [SCTRF_PTR_W-1:0] ptr_inc(input logic [SCTRF_PTR_W-1:0] p);
		ptr_inc = (p == SCTRF_MEM_LAST) ? '0 : p + 16'h0001;
	endfunction

	function automatic logic [2:0] res_clamp(input logic [2:0] s);
		res_clamp = (s > SCTRF_RES_MAX) ? SCTRF_RES_MAX : s;
	endfunction

	sctrf_state_e state_ff, nxt_state;
	logic to_mem_ff, trig_ext_ff, auto_ff;
	logic [3:0] func_ff;
	logic [2:0] range_ff, res_ff;
	logic [7:0] chans_ff, chan_ff;
	logic [SCTRF_PTR_W-1:0] wr_ptr_ff, count_ff, rd_idx_ff, left_ff;
	logic [SCTRF_DATA_W-1:0] mem_q_ff;
	logic [SCTRF_DATA_W-1:0] rmem [0:SCTRF_MEM_DEPTH-1];
	logic fifo_in_ready;

	// Command acceptance: stop commands are always taken; others wait for idle
	wire is_stop = (CMD_CODE == CMD_ABORT) || (CMD_CODE == CMD_DEV_CLEAR);
	wire scanning = (state_ff == ST_WAIT_TRIG) || (state_ff == ST_SAMPLE) || (state_ff == ST_CONVERT);
	assign CMD_READY = is_stop || (state_ff == ST_IDLE);
	wire cmd_take = CMD_VALID && CMD_READY;
	wire take_cfg = cmd_take && ((CMD_CODE == CMD_CONFIGURE) || (CMD_CODE == CMD_MEASURE));
	wire is_freq = (CMD_FUNC == SCTRF_FUNC_FREQ) || (CMD_FUNC == SCTRF_FUNC_PERIOD);
	wire dev_clear = cmd_take && (CMD_CODE == CMD_DEV_CLEAR);

	// Trigger and sweep progress
	wire trig_hit = !trig_ext_ff || EXT_TRIG;
	wire last_chan = (chan_ff + 8'h01 >= chans_ff);
	// Direct readings only start when the buffer has room, so a finished one always fits
	wire can_start = to_mem_ff || fifo_in_ready;
	wire meas_end = (state_ff == ST_CONVERT) && MEAS_DONE;
	wire mem_we = meas_end && to_mem_ff;
	wire direct_push = meas_end && !to_mem_ff;
	wire fetch_push = (state_ff == ST_FETCH_PUSH);
	wire fifo_in_valid = direct_push || fetch_push;
	wire [SCTRF_DATA_W-1:0] fifo_in_data = fetch_push ? mem_q_ff : MEAS_DATA;
	wire mem_full = (count_ff == SCTRF_MEM_FULL);
	wire [SCTRF_PTR_W-1:0] oldest = mem_full ? wr_ptr_ff : '0;

	always_comb
	begin
		nxt_state = state_ff;
		if (cmd_take)
		begin
			case (CMD_CODE)
				CMD_READ, CMD_INITIATE, CMD_MEASURE: nxt_state = ST_WAIT_TRIG;
				CMD_FETCH: nxt_state = (count_ff == '0) ? ST_IDLE : ST_FETCH_RD;
				default: nxt_state = ST_IDLE;
			endcase
		end
		else
		begin
			case (state_ff)
				ST_WAIT_TRIG: if (trig_hit) nxt_state = ST_SAMPLE;
				ST_SAMPLE: if (can_start) nxt_state = ST_CONVERT;
				ST_CONVERT: if (MEAS_DONE) nxt_state = last_chan ? ST_IDLE : ST_SAMPLE;
				ST_FETCH_RD: nxt_state = ST_FETCH_PUSH;
				ST_FETCH_PUSH: if (fifo_in_ready) nxt_state = (left_ff == 16'h0001) ? ST_IDLE : ST_FETCH_RD;
				default: nxt_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Measurement settings; function, range and autorange (both fixed for frequency/period), resolution and channels from the command, trigger source to default
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			func_ff <= SCTRF_FUNC_RST;
			range_ff <= SCTRF_RANGE_RST;
			auto_ff <= 1'b0;
			res_ff <= SCTRF_RES_DEF;
			chans_ff <= SCTRF_CHANS_RST;
			trig_ext_ff <= 1'b0;
		end
		else if (take_cfg)
		begin
			func_ff <= CMD_FUNC;
			range_ff <= is_freq ? SCTRF_FREQ_RANGE : CMD_RANGE;
			auto_ff <= CMD_RANGE_AUTO && !is_freq;
			res_ff <= res_clamp(CMD_RES_SEL);
			chans_ff <= (CMD_CHANS == 8'h00) ? SCTRF_CHANS_RST : CMD_CHANS;
			trig_ext_ff <= 1'b0;
		end
		else if (cmd_take && (CMD_CODE == CMD_TRIG_SOURCE))
			trig_ext_ff <= CMD_TRIG_EXT;
	end

	// Destination of the readings of the armed scan
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			to_mem_ff <= 1'b0;
		else if (cmd_take && (CMD_CODE == CMD_INITIATE))
			to_mem_ff <= 1'b1;
		else if (cmd_take && ((CMD_CODE == CMD_READ) || (CMD_CODE == CMD_MEASURE)))
			to_mem_ff <= 1'b0;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST || (state_ff == ST_WAIT_TRIG))
			chan_ff <= 8'h00;
		else if (meas_end)
			chan_ff <= chan_ff + 8'h01;
	end

	// Reading memory: no reset on the array, contents kept until the next initiate
	always_ff @(posedge REF_CLK)
	begin
		if (mem_we)
			rmem[wr_ptr_ff] <= MEAS_DATA;
		if (state_ff == ST_FETCH_RD)
			mem_q_ff <= rmem[rd_idx_ff];
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST || (cmd_take && (CMD_CODE == CMD_INITIATE)))
		begin
			wr_ptr_ff <= '0;
			count_ff <= '0;
		end
		else if (mem_we)
		begin
			wr_ptr_ff <= ptr_inc(wr_ptr_ff);
			if (!mem_full)
				count_ff <= count_ff + 16'h0001;
		end
	end

	// Fetch walks oldest to newest and never touches the write side
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			rd_idx_ff <= '0;
			left_ff <= '0;
		end
		else if (cmd_take && (CMD_CODE == CMD_FETCH))
		begin
			rd_idx_ff <= oldest;
			left_ff <= count_ff;
		end
		else if (fetch_push && fifo_in_ready)
		begin
			rd_idx_ff <= ptr_inc(rd_idx_ff);
			left_ff <= left_ff - 16'h0001;
		end
	end

	// Device clear also flushes the output buffer so no stale response mixes in
	sctrf_fifo #(.WIDTH(SCTRF_DATA_W), .DEPTH(SCTRF_FIFO_DEPTH)) u_obuf (
		.clk(REF_CLK),
		.rst(RST),
		.flush(dev_clear),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(OUT_VALID),
		.out_ready(OUT_READY),
		.out_data(OUT_DATA)
	);

	assign MEAS_START = (state_ff == ST_SAMPLE) && can_start && !cmd_take;
	assign MEAS_CHAN = chan_ff;
	assign CFG_FUNC = func_ff;
	assign CFG_RANGE = range_ff;
	assign CFG_AUTO_RANGE = auto_ff;
	assign CFG_INTEG_HPLC = SCTRF_INTEG_HPLC[res_ff];
	assign CFG_RES_BITS = SCTRF_RES_BITS[res_ff];
	assign TRIG_EXT_SEL = trig_ext_ff;
	assign SCAN_BUSY = (state_ff != ST_IDLE);
	assign MEM_COUNT = count_ff;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	cfg_no_arm_a: assert property (cmd_take && CMD_CODE == CMD_CONFIGURE |=> state_ff == ST_IDLE)
		else $error("configure armed the scan");
	read_arm_a: assert property (cmd_take && CMD_CODE == CMD_READ |=> state_ff == ST_WAIT_TRIG && !to_mem_ff)
		else $error("read did not arm");
	full_halt_a: assert property (state_ff == ST_SAMPLE && !to_mem_ff && !fifo_in_ready && !cmd_take
		|-> !MEAS_START ##1 state_ff == ST_SAMPLE)
		else $error("reading started with full buffer");
	direct_nomem_a: assert property (!to_mem_ff && scanning |=> $stable(count_ff))
		else $error("direct reading reached memory");
	mem_wrap_a: assert property (mem_we && wr_ptr_ff == SCTRF_MEM_LAST |=> wr_ptr_ff == '0)
		else $error("memory pointer did not wrap");
	mem_sat_a: assert property (mem_we && mem_full |=> count_ff == SCTRF_MEM_FULL)
		else $error("memory count passed its depth");
	mem_keep_a: assert property (state_ff == ST_IDLE && !cmd_take |=> $stable(count_ff))
		else $error("stored readings lost while idle");
	fetch_keep_a: assert property (state_ff == ST_FETCH_RD |=> $stable(count_ff) ##1 $stable(wr_ptr_ff))
		else $error("fetch disturbed memory");
	res_map_a: assert property (take_cfg && CMD_RES_SEL == 3'h0
		|=> CFG_INTEG_HPLC == 14'h0002 && CFG_RES_BITS == 5'h0f)
		else $error("resolution map wrong");
	freq_range_a: assert property (take_cfg && is_freq |=> CFG_RANGE == SCTRF_FREQ_RANGE && !CFG_AUTO_RANGE)
		else $error("frequency range not fixed");
	auto_rng_a: assert property (take_cfg && !is_freq && CMD_RANGE_AUTO |=> CFG_AUTO_RANGE)
		else $error("autorange not enabled");
	meas_imm_a: assert property (cmd_take && CMD_CODE == CMD_MEASURE ##1 !cmd_take
		|-> !trig_ext_ff ##1 state_ff == ST_SAMPLE)
		else $error("measure did not trigger at once");
	ext_wait_a: assert property (state_ff == ST_WAIT_TRIG && trig_ext_ff && !EXT_TRIG && !cmd_take
		|=> state_ff == ST_WAIT_TRIG)
		else $error("scan began without external pulse");
	fetch_hold_a: assert property (state_ff == ST_FETCH_RD
		|-> $past(state_ff) == ST_IDLE || $past(state_ff) == ST_FETCH_PUSH)
		else $error("fetch taken during scan");
	stop_scan_a: assert property (cmd_take && is_stop |=> state_ff == ST_IDLE)
		else $error("abort did not stop scan");
	sweep_end_a: assert property (meas_end && last_chan && !cmd_take |=> state_ff == ST_IDLE)
		else $error("trigger system not idle after sweep");

	read_done_c: cover property (direct_push ##[1:20] state_ff == ST_IDLE);
	fetch_run_c: cover property (state_ff == ST_FETCH_PUSH && fifo_in_ready && left_ff == 16'h0001);
	stall_c: cover property (state_ff == ST_SAMPLE && !can_start);
	abort_c: cover property (scanning && cmd_take && is_stop);
endmodule

//--- verif/scan_trigger_reading_flow_bench.sv
`timescale 1ns/1ps
module scan_trigger_reading_flow_bench
	import sctrf_pkg::*;
;
	logic clk, rst, cv, cr, oval, ordy, busy, mst, mdone, ext, slow;
	sctrf_cmd_e code;
	logic [3:0] func, cfg_func;
	logic [2:0] rng, res, cfg_rng;
	logic auto, text, cfg_auto, tsel;
	logic [7:0] chans, mchan;
	logic [31:0] mdata, odata;
	logic [13:0] integ;
	logic [4:0] rbits;
	logic [15:0] mcount, nrd;
	logic [31:0] saved [0:2];
	int err_total, checked, starts;

	sctrf_top dut (.REF_CLK(clk), .RST(rst), .CMD_VALID(cv), .CMD_READY(cr), .CMD_CODE(code),
		.CMD_FUNC(func), .CMD_RANGE(rng), .CMD_RANGE_AUTO(auto), .CMD_RES_SEL(res), .CMD_CHANS(chans),
		.CMD_TRIG_EXT(text), .EXT_TRIG(ext), .MEAS_START(mst), .MEAS_CHAN(mchan), .MEAS_DONE(mdone),
		.MEAS_DATA(mdata), .CFG_FUNC(cfg_func), .CFG_RANGE(cfg_rng), .CFG_AUTO_RANGE(cfg_auto),
		.CFG_INTEG_HPLC(integ), .CFG_RES_BITS(rbits), .TRIG_EXT_SEL(tsel), .OUT_VALID(oval),
		.OUT_READY(ordy), .OUT_DATA(odata), .SCAN_BUSY(busy), .MEM_COUNT(mcount));

	sctrf_front_model fe (.clk(clk), .rst(rst), .start(mst), .chan(mchan), .slow(slow),
		.done(mdone), .data(mdata));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk)
		if (mst === 1'b1)
			starts++;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
			err_total++;
		end
	endtask

	// Command is held until ready is seen, then dropped at the taking edge
	task send(input sctrf_cmd_e c);
		int n;
		n = 0;
		@(posedge clk);
		cv <= 1'b1;
		code <= c;
		@(negedge clk);
		while (cr !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		check(32'(cr), 32'h1);
		@(posedge clk);
		cv <= 1'b0;
	endtask

	// Reading words carry a running sequence number and the channel index
	task pop(input int n, input bit again);
		logic [31:0] e;
		int k;
		@(posedge clk);
		ordy <= 1'b1;
		for (int i = 0; i < n; i++)
		begin
			k = 0;
			e = again ? saved[i % 3] : {nrd, 8'h00, 8'(i)};
			@(negedge clk);
			while (oval !== 1'b1 && k < 400)
			begin
				@(negedge clk);
				k++;
			end
			check(odata, e);
			if (!again)
			begin
				saved[i % 3] = e;
				nrd++;
			end
			@(posedge clk);
		end
		ordy <= 1'b0;
	endtask

	task t_config;
		for (int i = 0; i < 7; i++)
		begin
			@(posedge clk);
			res <= 3'(i);
			send(CMD_CONFIGURE);
			@(negedge clk);
			check(32'(integ), 32'(SCTRF_INTEG_HPLC[i]));
			check(32'(rbits), 32'(SCTRF_RES_BITS[i]));
			check(32'(busy), 32'h0);
		end
		@(posedge clk);
		func <= SCTRF_FUNC_FREQ;
		rng <= 3'h5;
		auto <= 1'b1;
		send(CMD_CONFIGURE);
		@(negedge clk);
		check(32'(cfg_rng), 32'(SCTRF_FREQ_RANGE));
		check(32'(cfg_auto), 32'h0);
		@(posedge clk);
		func <= 4'h1;
		send(CMD_CONFIGURE);
		@(negedge clk);
		check(32'(cfg_auto), 32'h1);
		check(32'(cfg_func), 32'h1);
	endtask

	task t_ext;
		@(posedge clk);
		chans <= 8'h02;
		send(CMD_CONFIGURE);
		text <= 1'b1;
		send(CMD_TRIG_SOURCE);
		send(CMD_READ);
		starts = 0;
		repeat (20) @(negedge clk);
		check(32'(starts), 32'h0);
		check(32'(busy), 32'h1);
		check(32'(tsel), 32'h1);
		@(posedge clk);
		ext <= 1'b1;
		@(posedge clk);
		ext <= 1'b0;
		pop(2, 1'b0);
		@(negedge clk);
		check(32'(busy), 32'h0);
	endtask

	task t_measure;
		@(posedge clk);
		chans <= 8'h01;
		send(CMD_MEASURE);
		pop(1, 1'b0);
		check(32'(mcount), 32'h0);
		check(32'(tsel), 32'h0);
	endtask

	task t_fetch;
		slow <= 1'b1;
		chans <= 8'h03;
		send(CMD_CONFIGURE);
		send(CMD_INITIATE);
		send(CMD_FETCH);
		check(32'(mcount), 32'h3);
		pop(3, 1'b0);
		repeat (50) @(negedge clk);
		send(CMD_FETCH);
		pop(3, 1'b1);
		check(32'(mcount), 32'h3);
		slow <= 1'b0;
	endtask

	// Output buffer never drained, so the sweep must stall once it holds eight words
	task t_full;
		chans <= 8'h0a;
		send(CMD_CONFIGURE);
		send(CMD_READ);
		starts = 0;
		repeat (200) @(negedge clk);
		check(32'(starts), 32'h8);
		check(32'(mcount), 32'h3);
		send(CMD_DEV_CLEAR);
		@(negedge clk);
		check(32'(oval), 32'h0);
		check(32'(busy), 32'h0);
	endtask

	task t_abort;
		@(posedge clk);
		slow <= 1'b1;
		chans <= 8'h05;
		send(CMD_INITIATE);
		repeat (5) @(negedge clk);
		send(CMD_ABORT);
		@(negedge clk);
		check(32'(busy), 32'h0);
		// Let the aborted reading come back; it must not reach memory
		repeat (20) @(negedge clk);
		check(32'(mcount), 32'h0);
	endtask

	task finish_test;
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		err_total++;
		finish_test;
	end

	initial
	begin
		{cv, auto, text, ext, ordy, slow} = 6'h00;
		code = CMD_CONFIGURE;
		{func, rng, res} = 10'h000;
		chans = 8'h01;
		rst = 1'b1;
		nrd = 16'h0000;
		err_total = 0;
		checked = 0;
		starts = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check(32'(integ), 32'h64);
		check(32'(rbits), 32'h14);
		check(32'(busy), 32'h0);
		t_config;
		t_ext;
		t_measure;
		t_fetch;
		t_full;
		t_abort;
		finish_test;
	end
endmodule

//--- verif/sctrf_front_model.sv
`timescale 1ns/1ps
module sctrf_front_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Front end handshake
	input wire logic start,
	input wire logic [7:0] chan,
	input wire logic slow,
	output logic done,
	output logic [31:0] data
);
	logic [3:0] wait_ff;
	logic busy_ff;
	logic [15:0] seq_ff;
	logic [7:0] chan_ff;
	logic [31:0] last_ff;

	// Idle data is the inverse of the last word so a stale sample never matches
	always @(posedge clk)
	begin
		done <= 1'b0;
		data <= ~last_ff;
		if (rst)
		begin
			busy_ff <= 1'b0;
			seq_ff <= 16'h0000;
			last_ff <= 32'h0000_0000;
		end
		else if (start)
		begin
			busy_ff <= 1'b1;
			chan_ff <= chan;
			wait_ff <= slow ? 4'hb : 4'h1;
		end
		else if (busy_ff && wait_ff != 4'h0)
			wait_ff <= wait_ff - 4'h1;
		else if (busy_ff)
		begin
			busy_ff <= 1'b0;
			done <= 1'b1;
			data <= {seq_ff, 8'h00, chan_ff};
			last_ff <= {seq_ff, 8'h00, chan_ff};
			seq_ff <= seq_ff + 16'h0001;
		end
	end
endmodule
